// file: bench/tcw_pin_load.sv
// External load on the compare output pin: a pull-up and a high-time counter.
`timescale 1ns/100ps

module tcw_pin_load (
  input wire logic clock,
  input wire logic pin_out,
  input wire logic pin_oe,
  input wire logic clr,
  input wire logic meas,
  output logic pin_level,
  output logic [15:0] high_count
);
  // The pull-up sets the line level whenever the device releases the pin.
  assign pin_level = pin_oe ? pin_out : 1'b1;

  always_ff @(posedge clock) begin
    if (clr) begin
      high_count <= 16'h0000;
    end else if (meas && pin_level) begin
      high_count <= high_count + 16'h0001;
    end
  end
endmodule

// file: bench/testbench.sv
// Self-checking testbench for the compare waveform timer.
`timescale 1ns/100ps
`include "tcw_defines.svh"

module testbench;
  localparam logic [7:0] FORCE_ST [4] = '{8'h03, 8'h00, 8'h03, 8'h01};
  logic clock, rstn, clk_en, timer_tick, hsel, hwrite, hreadyout, hresp, clr, meas;
  logic [31:0] haddr, hwdata, hrdata, rdq;
  logic [1:0] htrans;
  logic [2:0] hsize;
  logic compare_output, overflow_flag, compare_flag, pin_out, pin_oe, pin_level;
  logic [15:0] high_count;
  int errors, n_compared;

  tcw_timer i_tcw_timer (.clock(clock), .rstn(rstn), .clk_en(clk_en), .timer_tick(timer_tick),
    .hsel(hsel), .haddr(haddr), .htrans(htrans), .hwrite(hwrite), .hsize(hsize),
    .hwdata(hwdata), .hready(hreadyout), .hreadyout(hreadyout), .hresp(hresp),
    .hrdata(hrdata), .compare_output(compare_output), .overflow_flag(overflow_flag),
    .compare_flag(compare_flag), .pin_out(pin_out), .pin_oe(pin_oe));

  tcw_pin_load i_tcw_pin_load (.clock(clock), .pin_out(pin_out), .pin_oe(pin_oe), .clr(clr),
    .meas(meas), .pin_level(pin_level), .high_count(high_count));

  always #5 clock = ~clock;

  task automatic stop_test();
    $display("errors=%0d compared=%0d", errors, n_compared);
    if (errors == 0 && n_compared > 0) begin
      $display("TEST PASSED");
    end else begin
      $display("TEST FAILED");
    end
    $finish;
  endtask

  task automatic chk(input string name, input logic [31:0] want, input logic [31:0] got);
    n_compared++;
    if (got !== want) begin
      $display("CHECK FAILED %s expected %h seen %h", name, want, got);
      errors++;
    end
  endtask

  // The request is held until hready is seen high, so a stalled slave is still served.
  task automatic bus(input logic wr, input logic [7:0] a, input logic [31:0] d);
    int n;
    @(posedge clock);
    hsel <= 1'b1;
    htrans <= 2'h2;
    haddr <= {24'h000000, a};
    hwrite <= wr;
    for (int p = 0; p < 2; p++) begin
      n = 0;
      do begin
        @(posedge clock);
        n++;
      end while (hreadyout !== 1'b1 && n < 50);
      if (n >= 50) begin
        errors++;
        stop_test();
      end
      if (p == 0) begin
        hsel <= 1'b0;
        htrans <= 2'h0;
        hwdata <= d;
      end
    end
    rdq = hrdata;
  endtask

  task automatic wr(input logic [7:0] a, input logic [31:0] d);
    bus(1'b1, a, d);
  endtask

  // Two idle cycles let registered status outputs settle before the read.
  task automatic rd(input logic [7:0] a, input logic [31:0] want, input string name);
    repeat (2) @(posedge clock);
    bus(1'b0, a, 32'h00000000);
    chk(name, want, rdq);
  endtask

  task automatic tick(input int n);
    repeat (n) begin
      @(posedge clock);
      timer_tick <= 1'b1;
      @(posedge clock);
      timer_tick <= 1'b0;
    end
  endtask

  // Runs long enough for the buffered compare to load, then counts pin high time.
  task automatic pwm(input logic [7:0] ctl, input logic [7:0] cmp, input int len,
      input int want);
    wr(`TCW_OFS_CTRL, {24'h000000, ctl});
    wr(`TCW_OFS_COMPARE, {24'h000000, cmp});
    @(posedge clock);
    timer_tick <= 1'b1;
    repeat (300) @(posedge clock);
    clr <= 1'b0;
    meas <= 1'b1;
    repeat (len) @(posedge clock);
    meas <= 1'b0;
    timer_tick <= 1'b0;
    @(posedge clock);
    chk("high_count", want, {16'h0000, high_count});
    clr <= 1'b1;
  endtask

  initial begin
    clock = 1'b0;
    rstn = 1'b0;
    clk_en = 1'b1;
    timer_tick = 1'b0;
    hsel = 1'b0;
    haddr = 32'h00000000;
    htrans = 2'h0;
    hwrite = 1'b0;
    hsize = 3'h2;
    hwdata = 32'h00000000;
    clr = 1'b1;
    meas = 1'b0;
    errors = 0;
    n_compared = 0;
    repeat (6) @(posedge clock);
    rstn <= 1'b1;
    rd(`TCW_OFS_STATUS, 32'h00000000, "status_reset");
    rd(`TCW_OFS_FLAGS, 32'h00000000, "flags_reset");
    wr(8'h40, 32'hFFFFFFFF);
    rd(8'h40, 32'h00000000, "unmapped");
    wr(`TCW_OFS_PORT, 32'h00000002);
    for (int c = 1; c < 5; c++) begin
      wr(`TCW_OFS_CTRL, 32'h00000080 | 32'((c % 4) << 2));
      rd(`TCW_OFS_STATUS, {24'h000000, FORCE_ST[c - 1]}, "status_force");
    end
    rd(`TCW_OFS_FLAGS, 32'h00000000, "flags_force");
    rd(`TCW_OFS_CTRL, 32'h00000000, "ctrl_read");
    chk("pin_oe", 32'h00000001, {31'h0, pin_oe});
    wr(`TCW_OFS_COMPARE, 32'h00000040);
    wr(`TCW_OFS_COUNT, 32'h000000FE);
    tick(2);
    rd(`TCW_OFS_COUNT, 32'h00000000, "count_wrap");
    rd(`TCW_OFS_FLAGS, 32'h00000001, "flags_ovf");
    chk("overflow_flag", 32'h00000001, {31'h0, overflow_flag});
    tick(3);
    rd(`TCW_OFS_FLAGS, 32'h00000001, "flags_sticky");
    rd(`TCW_OFS_COUNT, 32'h00000003, "count_run");
    // Ticks offered while the enable is low must be lost, not queued.
    @(posedge clock);
    clk_en <= 1'b0;
    timer_tick <= 1'b1;
    repeat (5) @(posedge clock);
    clk_en <= 1'b1;
    timer_tick <= 1'b0;
    rd(`TCW_OFS_COUNT, 32'h00000003, "count_frozen");
    wr(`TCW_OFS_CTRL, 32'h00000002);
    wr(`TCW_OFS_COMPARE, 32'h00000003);
    wr(`TCW_OFS_COUNT, 32'h00000000);
    wr(`TCW_OFS_FLAGS, 32'h00000003);
    tick(4);
    rd(`TCW_OFS_COUNT, 32'h00000000, "count_ctc");
    rd(`TCW_OFS_FLAGS, 32'h00000002, "flags_ctc");
    chk("compare_flag", 32'h00000001, {31'h0, compare_flag});
    rd(`TCW_OFS_STATUS, 32'h00000001, "status_com0");
    wr(`TCW_OFS_CTRL, 32'h00000006);
    tick(4);
    rd(`TCW_OFS_STATUS, 32'h00000000, "status_toggle1");
    tick(4);
    rd(`TCW_OFS_STATUS, 32'h00000003, "status_toggle2");
    chk("compare_output", 32'h00000001, {31'h0, compare_output});
    wr(`TCW_OFS_FLAGS, 32'h00000003);
    wr(`TCW_OFS_COUNT, 32'h0000000A);
    tick(245);
    rd(`TCW_OFS_FLAGS, 32'h00000000, "flags_missed");
    tick(1);
    rd(`TCW_OFS_COUNT, 32'h00000000, "count_missed");
    rd(`TCW_OFS_FLAGS, 32'h00000001, "flags_ctc_ovf");
    wr(`TCW_OFS_FLAGS, 32'h00000003);
    pwm(8'h0B, 8'h80, 256, 129);
    pwm(8'h0F, 8'h80, 256, 127);
    pwm(8'h0B, 8'hFF, 256, 256);
    pwm(8'h0F, 8'hFF, 256, 0);
    pwm(8'h0B, 8'h00, 256, 1);
    pwm(8'h07, 8'h80, 512, 256);
    rd(`TCW_OFS_FLAGS, 32'h00000003, "flags_pwm");
    wr(`TCW_OFS_PORT, 32'h00000000);
    repeat (3) @(posedge clock);
    chk("pin_oe_off", 32'h00000000, {31'h0, pin_oe});
    chk("pin_level", 32'h00000001, {31'h0, pin_level});
    chk("hresp", 32'h00000000, {31'h0, hresp});
    stop_test();
  end
endmodule

// file: verilog/tcw_defines.svh
// Offsets, field positions, reset values and limits of the compare waveform unit.
`ifndef TCW_DEFINES_SVH
`define TCW_DEFINES_SVH

`define TCW_OFS_CTRL 8'h00
`define TCW_OFS_COUNT 8'h04
`define TCW_OFS_COMPARE 8'h08
`define TCW_OFS_FLAGS 8'h0C
`define TCW_OFS_PORT 8'h10
`define TCW_OFS_STATUS 8'h14

`define TCW_CTRL_MODE_LSB 0
`define TCW_CTRL_MODE_MSB 1
`define TCW_CTRL_COM_LSB 2
`define TCW_CTRL_COM_MSB 3
`define TCW_CTRL_FORCE_BIT 7

`define TCW_FLAG_OVF_BIT 0
`define TCW_FLAG_CMP_BIT 1

`define TCW_PORT_DATA_BIT 0
`define TCW_PORT_DIR_BIT 1

`define TCW_STAT_OC_BIT 0
`define TCW_STAT_PIN_BIT 1

`define TCW_CNT_BOTTOM 8'h00
`define TCW_CNT_MAX 8'hFF
`define TCW_RST_BYTE 8'h00
`define TCW_RST_COM 2'h0
`define TCW_COM_TOGGLE 2'h1
`define TCW_COM_CLEAR 2'h2
`define TCW_COM_SET 2'h3

`endif

// file: verilog/tcw_pkg.sv
// Types shared by the compare waveform unit.
package tcw_pkg;

  typedef enum logic [1:0] {
    TCW_MODE_NORMAL = 2'h0,
    TCW_MODE_PHASE = 2'h1,
    TCW_MODE_CLEAR_ON_MATCH = 2'h2,
    TCW_MODE_FAST_PWM = 2'h3
  } tcw_mode_e;

  typedef logic [7:0] tcw_byte_t;

endpackage

// file: verilog/tcw_timer.sv
// Eight-bit timer with compare output waveform logic and an AHB-Lite register slave.
//
// Functional notes
// - Compare output state is its own register, cleared to zero by reset.
// - Nonzero output mode routes compare output to pin; direction bit still decides drive.
// - Output mode zero leaves compare output state untouched on a match.
// - New output mode acts at the next match; force acts at once in non-PWM modes.
// - Counting depends only on waveform mode; output mode picks action or polarity.
// - Waveform mode zero counts up only and wraps from 0xFF to 0x00.
// - Normal mode sets overflow flag as count becomes zero; counting never clears it.
// - Count value may be written by software at any time in normal mode.
// - Waveform mode two clears the count when it matches the compare value.
// - Clear-on-match compare writes are unbuffered; a missed match wraps through 0xFF.
// - Clear-on-match with output mode one toggles compare output on each match.
// - Clear-on-match sets overflow flag as the counter passes maximum to zero.
// - Clear-on-match raises compare flag each time the counter matches the compare value.
// - Waveform mode three counts zero to maximum, then clears on the next tick.
// - Fast PWM mode two clears on match, sets at bottom; mode three inverts this.
// - Fast PWM sets overflow flag each time the counter passes from maximum to zero.
// - Fast PWM period is 256 timer ticks.
// - Fast PWM compare zero gives one-tick spike; compare maximum gives constant level.
// - Fast PWM output mode one toggles on match, compare value stays buffered.
// - A match sets compare flag at the timer tick after count equals compare.
// - PWM modes load compare value from buffer only at top; others bypass buffer.
// - Force updates compare output like a match, without flag or counter clear.
`timescale 1ns/100ps
`include "tcw_defines.svh"

module tcw_timer (
  input wire logic clock,
  input wire logic rstn,
  input wire logic clk_en,
  input wire logic timer_tick,
  input wire logic hsel,
  input wire logic [31:0] haddr,
  input wire logic [1:0] htrans,
  input wire logic hwrite,
  input wire logic [2:0] hsize,
  input wire logic [31:0] hwdata,
  input wire logic hready,
  output logic hreadyout,
  output logic hresp,
  output logic [31:0] hrdata,
  output logic compare_output,
  output logic overflow_flag,
  output logic compare_flag,
  output logic pin_out,
  output logic pin_oe
);

  logic [7:0] dp_addr_ff;
  logic dp_write_ff;
  logic dp_valid_ff;
  logic [31:0] hrdata_ff;
  tcw_pkg::tcw_mode_e mode_ff;
  logic [1:0] compare_output_mode_ff;
  tcw_pkg::tcw_byte_t count_ff;
  tcw_pkg::tcw_byte_t compare_ff;
  tcw_pkg::tcw_byte_t buffer_ff;
  logic oc_ff;
  logic ovf_ff;
  logic cmp_ff;
  logic block_ff;
  logic force_ff;
  logic port_data_ff;
  logic pin_dir_ff;
  logic pin_out_ff;
  logic pin_oe_ff;
  logic addr_take;
  logic wr_ctrl;
  logic wr_count;
  logic wr_compare;
  logic wr_flags;
  logic wr_port;
  logic pwm_mode;
  logic new_pwm;
  logic tick;
  logic match;
  logic at_max;
  logic nxt_oc;
  tcw_pkg::tcw_byte_t nxt_count;
  logic [31:0] nxt_rdata;

  // The bus waits whenever the clock enable is low, so no access is lost while frozen.
  assign hreadyout = clk_en;
  assign hresp = 1'b0;
  assign hrdata = hrdata_ff;
  assign compare_output = oc_ff;
  assign overflow_flag = ovf_ff;
  assign compare_flag = cmp_ff;
  assign pin_out = pin_out_ff;
  assign pin_oe = pin_oe_ff;

  assign addr_take = hsel && htrans[1] && hready;
  assign wr_ctrl = dp_valid_ff && dp_write_ff && (dp_addr_ff == `TCW_OFS_CTRL);
  assign wr_count = dp_valid_ff && dp_write_ff && (dp_addr_ff == `TCW_OFS_COUNT);
  assign wr_compare = dp_valid_ff && dp_write_ff && (dp_addr_ff == `TCW_OFS_COMPARE);
  assign wr_flags = dp_valid_ff && dp_write_ff && (dp_addr_ff == `TCW_OFS_FLAGS);
  assign wr_port = dp_valid_ff && dp_write_ff && (dp_addr_ff == `TCW_OFS_PORT);

  assign pwm_mode = mode_ff[0];
  assign new_pwm = hwdata[`TCW_CTRL_MODE_LSB];
  assign tick = timer_tick;
  assign match = (count_ff == compare_ff) && !block_ff;
  assign at_max = (count_ff == `TCW_CNT_MAX);

  // Bus address phase capture and read data; reads answer in the data phase.
  always_ff @(posedge clock or negedge rstn) begin
    if (!rstn) begin
      dp_addr_ff <= `TCW_RST_BYTE;
      dp_write_ff <= 1'b0;
      dp_valid_ff <= 1'b0;
      hrdata_ff <= 32'h00000000;
    end else if (clk_en) begin
      dp_valid_ff <= addr_take;
      dp_write_ff <= hwrite;
      dp_addr_ff <= {haddr[7:2], 2'b00};
      if (addr_take && !hwrite) begin
        hrdata_ff <= nxt_rdata;
      end
    end
  end

  always_comb begin
    nxt_rdata = 32'h00000000;
    unique case ({haddr[7:2], 2'b00})
      `TCW_OFS_CTRL: begin
        nxt_rdata[`TCW_CTRL_MODE_MSB:`TCW_CTRL_MODE_LSB] = mode_ff;
        nxt_rdata[`TCW_CTRL_COM_MSB:`TCW_CTRL_COM_LSB] = compare_output_mode_ff;
      end
      `TCW_OFS_COUNT: begin
        nxt_rdata[7:0] = count_ff;
      end
      `TCW_OFS_COMPARE: begin
        nxt_rdata[7:0] = pwm_mode ? buffer_ff : compare_ff;
      end
      `TCW_OFS_FLAGS: begin
        nxt_rdata[`TCW_FLAG_OVF_BIT] = ovf_ff;
        nxt_rdata[`TCW_FLAG_CMP_BIT] = cmp_ff;
      end
      `TCW_OFS_PORT: begin
        nxt_rdata[`TCW_PORT_DATA_BIT] = port_data_ff;
        nxt_rdata[`TCW_PORT_DIR_BIT] = pin_dir_ff;
      end
      `TCW_OFS_STATUS: begin
        nxt_rdata[`TCW_STAT_OC_BIT] = oc_ff;
        nxt_rdata[`TCW_STAT_PIN_BIT] = pin_out_ff;
      end
      default: begin
        nxt_rdata = 32'h00000000;
      end
    endcase
  end

  // Control register; the force bit is a strobe that is never stored and reads zero.
  always_ff @(posedge clock or negedge rstn) begin
    if (!rstn) begin
      mode_ff <= tcw_pkg::TCW_MODE_NORMAL;
      compare_output_mode_ff <= `TCW_RST_COM;
      force_ff <= 1'b0;
    end else if (clk_en) begin
      force_ff <= wr_ctrl && hwdata[`TCW_CTRL_FORCE_BIT] && !new_pwm;
      if (wr_ctrl) begin
        mode_ff <= tcw_pkg::tcw_mode_e'(hwdata[`TCW_CTRL_MODE_MSB:`TCW_CTRL_MODE_LSB]);
        compare_output_mode_ff <= hwdata[`TCW_CTRL_COM_MSB:`TCW_CTRL_COM_LSB];
      end
    end
  end

  // Next counter value; a software write has priority over counting.
  always_comb begin
    nxt_count = count_ff;
    unique case (mode_ff)
      tcw_pkg::TCW_MODE_NORMAL: begin
        nxt_count = count_ff + 8'h01;
      end
      tcw_pkg::TCW_MODE_CLEAR_ON_MATCH: begin
        nxt_count = match ? `TCW_CNT_BOTTOM : count_ff + 8'h01;
      end
      tcw_pkg::TCW_MODE_FAST_PWM: begin
        nxt_count = at_max ? `TCW_CNT_BOTTOM : count_ff + 8'h01;
      end
      tcw_pkg::TCW_MODE_PHASE: begin
        nxt_count = count_ff;
      end
    endcase
  end

  // Counter and the one-tick match block that follows a count write.
  always_ff @(posedge clock or negedge rstn) begin
    if (!rstn) begin
      count_ff <= `TCW_RST_BYTE;
      block_ff <= 1'b0;
    end else if (clk_en) begin
      if (wr_count) begin
        count_ff <= hwdata[7:0];
        block_ff <= 1'b1;
      end else if (tick) begin
        count_ff <= nxt_count;
        block_ff <= 1'b0;
      end
    end
  end

  // Compare value and its buffer; PWM loads only at the top so no pulse is cut short.
  always_ff @(posedge clock or negedge rstn) begin
    if (!rstn) begin
      compare_ff <= `TCW_RST_BYTE;
      buffer_ff <= `TCW_RST_BYTE;
    end else if (clk_en) begin
      if (wr_compare) begin
        buffer_ff <= hwdata[7:0];
      end
      if (wr_compare && !pwm_mode) begin
        compare_ff <= hwdata[7:0];
      end else if (pwm_mode && tick && at_max) begin
        compare_ff <= buffer_ff;
      end
    end
  end

  // Flags; a hardware set in the same cycle as a write-one clear wins.
  always_ff @(posedge clock or negedge rstn) begin
    if (!rstn) begin
      ovf_ff <= 1'b0;
      cmp_ff <= 1'b0;
    end else if (clk_en) begin
      if (tick && at_max && !wr_count && (mode_ff != tcw_pkg::TCW_MODE_PHASE)) begin
        ovf_ff <= 1'b1;
      end else if (wr_flags && hwdata[`TCW_FLAG_OVF_BIT]) begin
        ovf_ff <= 1'b0;
      end
      if (tick && match && (mode_ff != tcw_pkg::TCW_MODE_PHASE)) begin
        cmp_ff <= 1'b1;
      end else if (wr_flags && hwdata[`TCW_FLAG_CMP_BIT]) begin
        cmp_ff <= 1'b0;
      end
    end
  end

  // Waveform generator for the compare output state.
  always_comb begin
    nxt_oc = oc_ff;
    if (!pwm_mode && (force_ff || (tick && match))) begin
      unique case (compare_output_mode_ff)
        `TCW_COM_TOGGLE: nxt_oc = !oc_ff;
        `TCW_COM_CLEAR: nxt_oc = 1'b0;
        `TCW_COM_SET: nxt_oc = 1'b1;
        default: nxt_oc = oc_ff;
      endcase
    end else if ((mode_ff == tcw_pkg::TCW_MODE_FAST_PWM) && tick) begin
      // Bottom outranks the match so a compare value at maximum gives a steady level.
      unique case (compare_output_mode_ff)
        `TCW_COM_TOGGLE: nxt_oc = match ? !oc_ff : oc_ff;
        `TCW_COM_CLEAR: nxt_oc = at_max ? 1'b1 : (match ? 1'b0 : oc_ff);
        `TCW_COM_SET: nxt_oc = at_max ? 1'b0 : (match ? 1'b1 : oc_ff);
        default: nxt_oc = oc_ff;
      endcase
    end
  end

  always_ff @(posedge clock or negedge rstn) begin
    if (!rstn) begin
      oc_ff <= 1'b0;
    end else if (clk_en) begin
      oc_ff <= nxt_oc;
    end
  end

  // Port register and pin override; the direction bit alone enables the driver.
  always_ff @(posedge clock or negedge rstn) begin
    if (!rstn) begin
      port_data_ff <= 1'b0;
      pin_dir_ff <= 1'b0;
      pin_out_ff <= 1'b0;
      pin_oe_ff <= 1'b0;
    end else if (clk_en) begin
      if (wr_port) begin
        port_data_ff <= hwdata[`TCW_PORT_DATA_BIT];
        pin_dir_ff <= hwdata[`TCW_PORT_DIR_BIT];
      end
      pin_out_ff <= (compare_output_mode_ff != `TCW_RST_COM) ? oc_ff : port_data_ff;
      pin_oe_ff <= pin_dir_ff;
    end
  end

  default clocking cb @(posedge clock); endclocking
  default disable iff (!rstn);

  property p_oc_reset;
    $rose(rstn) |-> !oc_ff;
  endproperty
  a_oc_reset: assert property (p_oc_reset) else $error("Output state not zero after reset.");

  property p_override;
    clk_en |=> pin_out_ff == (($past(compare_output_mode_ff) != 2'h0) ?
      $past(oc_ff) : $past(port_data_ff));
  endproperty
  a_override: assert property (p_override) else $error("Pin value has the wrong source.");

  property p_com_zero;
    clk_en && (compare_output_mode_ff == 2'h0) |=> $stable(oc_ff);
  endproperty
  a_com_zero: assert property (p_com_zero) else $error("Output changed with mode zero.");

  property p_normal_wrap;
    clk_en && tick && (mode_ff == tcw_pkg::TCW_MODE_NORMAL) && at_max && !wr_count
      |=> (count_ff == 8'h00) && ovf_ff;
  endproperty
  a_normal_wrap: assert property (p_normal_wrap) else $error("Normal wrap or flag wrong.");

  property p_ctc_clear;
    clk_en && tick && (mode_ff == tcw_pkg::TCW_MODE_CLEAR_ON_MATCH) && match && !wr_count
      |=> (count_ff == 8'h00) && cmp_ff;
  endproperty
  a_ctc_clear: assert property (p_ctc_clear) else $error("Match did not clear counter.");

  property p_cmp_flag;
    clk_en && tick && match && !pwm_mode |=> cmp_ff;
  endproperty
  a_cmp_flag: assert property (p_cmp_flag) else $error("Compare flag not set on match.");

  property p_force_quiet;
    clk_en && force_ff && !cmp_ff && !(tick && match) |=> !cmp_ff;
  endproperty
  a_force_quiet: assert property (p_force_quiet) else $error("Force raised compare flag.");

  property p_fast_bottom;
    clk_en && tick && (mode_ff == tcw_pkg::TCW_MODE_FAST_PWM) && at_max && !wr_count &&
      (compare_output_mode_ff == 2'h2) |=> oc_ff && (count_ff == 8'h00);
  endproperty
  a_fast_bottom: assert property (p_fast_bottom) else $error("Output not set at bottom.");

  property p_buffered;
    clk_en && pwm_mode && !(tick && at_max) |=> $stable(compare_ff);
  endproperty
  a_buffered: assert property (p_buffered) else $error("Compare loaded off the top.");

  c_ctc_toggle: cover property (tick && match && mode_ff == tcw_pkg::TCW_MODE_CLEAR_ON_MATCH
    && compare_output_mode_ff == 2'h1);
  c_fast_wrap: cover property (tick && at_max && mode_ff == tcw_pkg::TCW_MODE_FAST_PWM);
  c_force: cover property (force_ff && compare_output_mode_ff != 2'h0);

endmodule
